// *** src/anr_pkg.sv ***
// Shared constants and carriers for the auto-negotiation ability registers
package anr_pkg;
	// Bus geometry
	localparam int ANR_ADDR_W = 8;
	localparam int ANR_DATA_W = 32;
	localparam int ANR_REG_W = 16;

	// Register indices; byte address is four times the index
	localparam logic [5:0] ANR_IDX_ADVERT = 6'h04;
	localparam logic [5:0] ANR_IDX_PARTNER = 6'h05;
	localparam logic [5:0] ANR_IDX_PAGE_STS = 6'h06;

	// Field positions, shared by both ability words; the page-received bit is in the page status word
	localparam int ANR_BIT_NEXT_PAGE = 15;
	localparam int ANR_BIT_ACK = 14;
	localparam int ANR_BIT_RFAULT = 13;
	localparam int ANR_BIT_PAUSE = 10;
	localparam int ANR_BIT_T4 = 9;
	localparam int ANR_BIT_TX_FD = 8;
	localparam int ANR_BIT_TX_HD = 7;
	localparam int ANR_BIT_T_FD = 6;
	localparam int ANR_BIT_T_HD = 5;
	localparam int ANR_SEL_HI = 4;
	localparam int ANR_SEL_LO = 0;
	localparam int ANR_BIT_PAGE_RCVD = 0;

	// Selector encodings
	localparam logic [4:0] ANR_SEL_IEEE8023 = 5'h01;
	localparam logic [4:0] ANR_SEL_IEEE8029 = 5'h02;

	// Reset values and access masks
	localparam logic [15:0] ANR_ADV_RESET = 16'h0001;
	localparam logic [15:0] ANR_ADV_WR_MASK = 16'h27ff;
	localparam logic [15:0] ANR_LP_MASK = 16'he7ff;
	localparam logic [15:0] ANR_LP_RESET = 16'h0000;

	// Identical words needed before a page counts as received
	localparam logic [1:0] ANR_PAGE_MATCHES = 2'h3;

	// AXI responses
	localparam logic [1:0] ANR_RESP_OKAY = 2'h0;
	localparam logic [1:0] ANR_RESP_SLVERR = 2'h2;

	// Write channel states
	typedef enum logic [1:0] {
		ANR_WR_IDLE = 2'b00,
		ANR_WR_HAVE_AW = 2'b01,
		ANR_WR_HAVE_W = 2'b10,
		ANR_WR_RESP = 2'b11
	} anr_wr_state_t;

	// Configuration strap pins, raw from the package balls
	typedef struct packed {
		logic duplex_strap_pin;
		logic speed100_strap_pin;
		logic speed10_strap_pin;
	} anr_straps_t;

	// Link code word from the negotiation receiver
	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} anr_lcw_t;
endpackage

// *** src/anr_ability_regs.sv ***
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
// What this block does
// - Writable pause advert bit ten, default zero
// - Writable T4 advert bit nine, default zero
// - Writable technology advert bits eight to five
// - TX full-duplex default: duplex strap AND 100 strap
// - TX half-duplex default: 100 speed strap
// - 10M full-duplex default: duplex strap AND 10 strap
// - 10M half-duplex default: 10 speed strap
// - Writable selector field, default 802.3 code
// - Writable remote fault bit thirteen, default zero
// - Partner next page readable; local next page zero
// - Partner acknowledge readable at bit fourteen
// - Partner pause and remote fault readable
// - Partner technology abilities readable, bits nine-five
// - Partner selector code readable in bits four-zero
// - Page after three identical words, latched until read
module anr_ability_regs (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Strap pins, asynchronous to clk
	input wire anr_pkg::anr_straps_t straps,
	// Link code words from the negotiation receiver, same clock
	input wire anr_pkg::anr_lcw_t lcw_in,
	// Results toward the negotiation logic
	output logic [15:0] adv_word,
	output logic page_rcvd,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	import anr_pkg::*;

	// Strap synchronisers; first stage feeds only the second
	anr_straps_t strap_meta_r;
	anr_straps_t strap_sync_r;
	// One-shot strap load after reset release
	logic strap_load_r;

	// Architectural registers
	logic [15:0] adv_r; // Local advertisement
	logic [15:0] adv_nxt;
	logic [15:0] lp_r; // Partner ability
	logic [15:0] lp_nxt;
	logic page_rcvd_r; // Sticky page-received flag
	logic page_rcvd_nxt;

	// Consecutive-word matcher
	logic [15:0] last_word_r;
	logic [1:0] match_cnt_r;
	logic [1:0] match_cnt_nxt;

	// Write channel state and captured halves
	anr_wr_state_t wr_state_r;
	anr_wr_state_t wr_state_nxt;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r;

	// Read channel holding registers
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Handshake terms
	wire aw_fire;
	wire w_fire;
	wire ar_fire;
	wire wr_commit;
	// Effective write operands once both halves are present
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [15:0] wr_be;
	// Write decode
	wire wr_hit_adv;
	wire wr_mapped;
	wire adv_we;
	// Read decode
	wire rd_hit_adv;
	wire rd_hit_lp;
	wire rd_hit_sts;
	wire rd_mapped;
	wire rd_clr_page;
	wire [31:0] rd_mux;
	// Word matcher terms
	wire same_word;
	wire page_done;
	// Strap-derived technology defaults
	wire [3:0] strap_tech;

	// Protection bits carry no meaning for these registers
	wire unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

	// Ready only while enabled, so a frozen block never swallows a beat
	assign s_axi_awready = ce && (wr_state_r == ANR_WR_IDLE || wr_state_r == ANR_WR_HAVE_W);
	assign s_axi_wready = ce && (wr_state_r == ANR_WR_IDLE || wr_state_r == ANR_WR_HAVE_AW);
	assign s_axi_bvalid = (wr_state_r == ANR_WR_RESP);
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	// Commit when the second half arrives, or both in one beat
	assign wr_commit = (wr_state_r == ANR_WR_IDLE && aw_fire && w_fire) ||
		(wr_state_r == ANR_WR_HAVE_AW && w_fire) ||
		(wr_state_r == ANR_WR_HAVE_W && aw_fire);

	// Pick the live channel or the captured copy
	assign wr_addr = (wr_state_r == ANR_WR_HAVE_AW) ? awaddr_r : s_axi_awaddr;
	assign wr_data = (wr_state_r == ANR_WR_HAVE_W) ? wdata_r : s_axi_wdata;
	assign wr_strb = (wr_state_r == ANR_WR_HAVE_W) ? wstrb_r : s_axi_wstrb;
	// Only the two low byte lanes reach the 16-bit registers
	assign wr_be = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// Write decode on the word index
	assign wr_hit_adv = (wr_addr[7:2] == ANR_IDX_ADVERT);
	assign wr_mapped = wr_hit_adv || (wr_addr[7:2] == ANR_IDX_PARTNER) ||
		(wr_addr[7:2] == ANR_IDX_PAGE_STS);
	assign adv_we = wr_commit && wr_hit_adv;

	// Read decode
	assign rd_hit_adv = (s_axi_araddr[7:2] == ANR_IDX_ADVERT);
	assign rd_hit_lp = (s_axi_araddr[7:2] == ANR_IDX_PARTNER);
	assign rd_hit_sts = (s_axi_araddr[7:2] == ANR_IDX_PAGE_STS);
	assign rd_mapped = rd_hit_adv || rd_hit_lp || rd_hit_sts;
	assign rd_clr_page = ar_fire && rd_hit_sts;

	// Upper bits and unmapped words read as zero
	assign rd_mux = rd_hit_adv ? {16'h0000, adv_r} :
		rd_hit_lp ? {16'h0000, lp_r} :
		rd_hit_sts ? {31'h00000000, page_rcvd_r} :
		32'h00000000;

	// Default technology bits, in field order TX FD, TX HD, 10 FD, 10 HD
	assign strap_tech = {
		strap_sync_r.duplex_strap_pin & strap_sync_r.speed100_strap_pin,
		strap_sync_r.speed100_strap_pin,
		strap_sync_r.duplex_strap_pin & strap_sync_r.speed10_strap_pin,
		strap_sync_r.speed10_strap_pin
	};

	// Three identical consecutive words make a page
	assign same_word = (lcw_in.word == last_word_r) && (match_cnt_r != 2'h0);
	assign page_done = lcw_in.valid && same_word &&
		(match_cnt_r == ANR_PAGE_MATCHES - 2'h1);

	// Results toward negotiation logic come straight from flops
	assign adv_word = adv_r;
	assign page_rcvd = page_rcvd_r;

	// Strap synchronisers run through reset so straps settle meanwhile
	// No reset on these stages: straps are static levels, and a reset
	// here would only delay the first clean sample after release
	always_ff @(posedge clk) begin
		if (ce) begin
			strap_meta_r <= straps;
			strap_sync_r <= strap_meta_r;
		end
	end

	// Advertisement next value
	always_comb begin
		adv_nxt = adv_r;
		// Straps load once, on the first enabled cycle after release
		if (strap_load_r) begin
			adv_nxt[ANR_BIT_TX_FD:ANR_BIT_T_HD] = strap_tech;
		end
		// Software write merges only the writable bits under byte enables
		if (adv_we) begin
			adv_nxt = (adv_nxt & ~(ANR_ADV_WR_MASK & wr_be)) |
				(wr_data[15:0] & ANR_ADV_WR_MASK & wr_be);
		end
		// Next page and reserved bits stay zero whatever is written
		adv_nxt = adv_nxt & ANR_ADV_WR_MASK;
	end

	// Partner word and page flag next values
	always_comb begin
		lp_nxt = lp_r;
		// Only a confirmed page updates the partner view
		if (page_done) begin
			lp_nxt = lcw_in.word & ANR_LP_MASK;
		end
		// A new page beats a clearing read in the same cycle
		page_rcvd_nxt = page_done || (page_rcvd_r && !rd_clr_page);
	end

	// Match counter saturates; a different word restarts at one
	always_comb begin
		match_cnt_nxt = match_cnt_r;
		if (lcw_in.valid) begin
			if (!same_word) begin
				match_cnt_nxt = 2'h1;
			end else if (match_cnt_r != ANR_PAGE_MATCHES) begin
				match_cnt_nxt = match_cnt_r + 2'h1;
			end
		end
	end

	// Write channel sequencing
	always_comb begin
		wr_state_nxt = wr_state_r;
		case (wr_state_r)
			ANR_WR_IDLE: begin
				if (aw_fire && w_fire) begin
					wr_state_nxt = ANR_WR_RESP;
				end else if (aw_fire) begin
					wr_state_nxt = ANR_WR_HAVE_AW;
				end else if (w_fire) begin
					wr_state_nxt = ANR_WR_HAVE_W;
				end
			end
			ANR_WR_HAVE_AW: begin
				if (w_fire) begin
					wr_state_nxt = ANR_WR_RESP;
				end
			end
			ANR_WR_HAVE_W: begin
				if (aw_fire) begin
					wr_state_nxt = ANR_WR_RESP;
				end
			end
			ANR_WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_nxt = ANR_WR_IDLE;
				end
			end
			default: begin
				wr_state_nxt = ANR_WR_IDLE;
			end
		endcase
	end

	// Ability registers and strap load flag
	always_ff @(posedge clk) begin
		if (rst) begin
			adv_r <= ANR_ADV_RESET;
			lp_r <= ANR_LP_RESET;
			page_rcvd_r <= 1'b0;
			strap_load_r <= 1'b1;
		end else if (ce) begin
			adv_r <= adv_nxt;
			lp_r <= lp_nxt;
			page_rcvd_r <= page_rcvd_nxt;
			strap_load_r <= 1'b0;
		end
	end

	// Word matcher history
	always_ff @(posedge clk) begin
		if (rst) begin
			last_word_r <= 16'h0000;
			match_cnt_r <= 2'h0;
		end else if (ce) begin
			if (lcw_in.valid) begin
				last_word_r <= lcw_in.word;
			end
			match_cnt_r <= match_cnt_nxt;
		end
	end

	// Write state and response code
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_state_r <= ANR_WR_IDLE;
			bresp_r <= ANR_RESP_OKAY;
		end else if (ce) begin
			wr_state_r <= wr_state_nxt;
			// Read-only words accept and ignore; holes answer an error
			if (wr_commit) begin
				bresp_r <= wr_mapped ? ANR_RESP_OKAY : ANR_RESP_SLVERR;
			end
		end
	end

	// Hold whichever half arrives first
	always_ff @(posedge clk) begin
		if (rst) begin
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else if (ce) begin
			if (aw_fire) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	// Read data is captured at the address beat and held until taken
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= ANR_RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_mapped ? ANR_RESP_OKAY : ANR_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
endmodule

// *** tb/anr_ability_checker.sv ***
`timescale 1ns/100ps
// Watches the bus handshakes and the advert word
module anr_ability_checker (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Advert word
	input wire logic [15:0] adv_word,
	// Sticky page flag
	input wire logic page_rcvd,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata
);
	import anr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	resv_zero_a: assert property (
		(adv_word & ~ANR_ADV_WR_MASK) == 16'h0000) else $error("advert reserved set");
	b_timing_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
	b_drop_a: assert property (
		ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	r_timing_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	ar_block_a: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	ce_stall_a: assert property (
		!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready)) else $error("ready in stall");
	rdata_hi_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read data set");
	// Advert changes only through a write or the strap load
	adv_quiet_a: assert property (
		!s_axi_awvalid && !s_axi_wvalid && !$past(rst) |=> $stable(adv_word))
		else $error("advert changed alone");
	// Page flag only falls through a taken read
	page_hold_a: assert property (
		page_rcvd && !(s_axi_arvalid && s_axi_arready) |=> page_rcvd)
		else $error("page flag dropped without read");
endmodule
bind anr_ability_regs anr_ability_checker u_chk (.clk(clk), .rst(rst), .ce(ce),
	.adv_word(adv_word), .page_rcvd(page_rcvd),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// *** tb/anr_lp_model.sv ***
`timescale 1ns/100ps
// Remote partner repeating one base page
module anr_lp_model (
	input wire logic clk,
	output anr_pkg::anr_lcw_t lcw
);
	import anr_pkg::*;
	initial lcw = '0;
	// Idle cycles carry inverted data so stale words never look valid
	task automatic send(input logic [15:0] w, input int n, input int gap);
		repeat (n) begin
			@(posedge clk);
			lcw <= '{1'b1, w};
			@(posedge clk);
			lcw <= '{1'b0, ~w};
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule

// *** tb/anr_ability_regs_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module anr_ability_regs_tb_top;
	import anr_pkg::*;
	// Counters and stimulus state
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [31:0] lf, d;
	logic [31:0] cw [4] = '{32'hffffffff, 32'h0, 32'h00000402, 32'h00002201};
	logic clk, rst, ce, page_rcvd;
	anr_straps_t straps;
	anr_lcw_t lcw;
	logic [15:0] adv_word, w;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, r;
	logic [3:0] wstrb;
	anr_ability_regs u_anr_ability_regs (.clk(clk), .rst(rst), .ce(ce), .straps(straps),
		.lcw_in(lcw), .adv_word(adv_word), .page_rcvd(page_rcvd),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp));
	anr_lp_model u_anr_lp_model (.clk(clk), .lcw(lcw));
	always #4 clk = ~clk;
	// Random source
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Advert after reset, from the straps
	function automatic logic [15:0] adv_def(input anr_straps_t s);
		return {7'h00, s.duplex_strap_pin & s.speed100_strap_pin, s.speed100_strap_pin,
			s.duplex_strap_pin & s.speed10_strap_pin, s.speed10_strap_pin, ANR_SEL_IEEE8023};
	endfunction
	task automatic results();
		$display("checked %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic do_rst(input anr_straps_t s);
		@(posedge clk);
		straps <= s;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
		int i;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= dv;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (i == 100) begin
			n_mismatch++;
			results();
		end
	endtask
	// Read and compare data and response
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int i;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				`CHK("rdata", e, rdata)
				`CHK("rresp", er, rresp)
				rready <= 1'b0;
				break;
			end
		end
		if (i == 100) begin
			n_mismatch++;
			results();
		end
	endtask
	initial begin
		{clk, awvalid, wvalid, bready, arvalid, rready} = '0;
		{rst, ce} = 2'b11;
		{straps, awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		lf = 32'h00016a90;
		// Every strap combination through a fresh reset
		for (int k = 0; k < 8; k++) begin
			do_rst(anr_straps_t'(k[2:0]));
			rc(8'h10, {16'h0, adv_def(anr_straps_t'(k[2:0]))}, ANR_RESP_OKAY);
			rc(8'h14, 32'h0, ANR_RESP_OKAY);
		end
		// Corner words first, then random ones
		for (int k = 0; k < 12; k++) begin
			lf = nx(lf);
			d = (k < 4) ? cw[k] : lf;
			wr(8'h10, d, r);
			`CHK("bresp", ANR_RESP_OKAY, r)
			rc(8'h10, {16'h0, d[15:0] & ANR_ADV_WR_MASK}, ANR_RESP_OKAY);
			`CHK("adv_word", d[15:0] & ANR_ADV_WR_MASK, adv_word)
		end
		// Upper byte lane only: the low byte of the advert keeps its value
		wstrb <= 4'h2;
		wr(8'h10, ~d, r);
		wstrb <= 4'hf;
		`CHK("bresp", ANR_RESP_OKAY, r)
		w = ((~d[15:0] & 16'hff00) | (d[15:0] & 16'h00ff)) & ANR_ADV_WR_MASK;
		rc(8'h10, {16'h0, w}, ANR_RESP_OKAY);
		`CHK("adv_word", w, adv_word)
		// Read-only and unmapped places
		wr(8'h14, lf, r);
		`CHK("bresp", ANR_RESP_OKAY, r)
		rc(8'h14, 32'h0, ANR_RESP_OKAY);
		wr(8'h20, lf, r);
		`CHK("bresp", ANR_RESP_SLVERR, r)
		rc(8'h20, 32'h0, ANR_RESP_SLVERR);
		@(posedge clk) ce <= 1'b0;
		@(posedge clk) ce <= 1'b1;
		// Two words, then a new word twice with gaps: no page yet
		lf = nx(lf);
		w = lf[15:0];
		u_anr_lp_model.send(~w, 2, 0);
		u_anr_lp_model.send(w, 2, 1);
		repeat (2) @(posedge clk);
		`CHK("page_rcvd", 1'b0, page_rcvd)
		rc(8'h14, 32'h0, ANR_RESP_OKAY);
		u_anr_lp_model.send(w, 1, 0);
		repeat (2) @(posedge clk);
		`CHK("page_rcvd", 1'b1, page_rcvd)
		rc(8'h14, {16'h0, w & ANR_LP_MASK}, ANR_RESP_OKAY);
		rc(8'h18, 32'h1, ANR_RESP_OKAY);
		`CHK("page_rcvd", 1'b0, page_rcvd)
		rc(8'h18, 32'h0, ANR_RESP_OKAY);
		results();
	end
endmodule
